// ==== verilog/bpm_top.sv ====
// beacon timing: pair decoder, blanking, reply delay, priority merge, rate loop
// Functional notes
// - distance reply leaves exactly 50 us after its decoded interrogation
// - while keyed, identification pulses run at 1350 per second
// - identification gated by external call-sign keying input
// - reference bursts top priority, interrupting any other source
// - identification second, yields only to reference bursts
// - replies third, dropped during bursts or keying
// - squitter fills lowest priority to keep rate constant
// - one decode pulse per pair spaced 12 us, others ignored
// - receiver blanked 40 us after each decode
// - decoded output pulses at least 65 us apart
// - receiver disabled during each 10 us transmit keying
// - loop holds decode rate at 2700 +/- 90 per second
// - decoded pulse counter drives gain feedback value
// - fine trigger gives six pulses 24 us apart
// - coarse trigger gives twelve pulses 30 us apart
// - merged pulse sent as pair 12 us apart; one arriving mid-pair is lost unless a reference pulse, which restarts the pair
`timescale 1ns/1ns
`default_nettype none
module bpm_top
    import bpm_pkg::*;
#(
    parameter int ZERO_DIST = ZERO_DIST_CYC,
    parameter int RATE_WIN = RATE_WIN_CYC,
    parameter int SQ_PERIOD = SQ_PERIOD_CYC,
    parameter int ID_PERIOD = ID_PERIOD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic video_i,
    input wire logic fine_trig_i,
    input wire logic coarse_trig_i,
    input wire logic id_key_i,
    output logic tx_pulse_o,
    output logic tx_key_o,
    output logic rx_blank_o,
    output logic decode_o,
    output logic [GAIN_W-1:0] gain_o,
    output logic reply_drop_o
);
    bpm_stream_if #(.W(TS_W)) q_in ();
    bpm_stream_if #(.W(TS_W)) q_out ();
    logic [TS_W-1:0] now_r;
    logic vid_d_r;
    logic vid_rise;
    logic [15:0] pair_cnt_r;
    logic pair_arm_r;
    logic [15:0] dblank_r;
    logic [15:0] gap_r;
    logic [15:0] txk_r;
    logic dec_hit;
    logic ref_pulse;
    logic ref_busy;
    logic [15:0] id_cnt_r;
    logic id_pulse;
    logic dist_due;
    logic [31:0] sq_cnt_r;
    logic sq_pulse;
    logic merge_pulse;
    logic [15:0] enc_r;
    logic enc_busy_r;
    logic [31:0] win_r;
    logic [15:0] dec_cnt_r;

    bpm_burst_gen u_burst (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .fine_trig_i(fine_trig_i),
        .coarse_trig_i(coarse_trig_i),
        .pulse_o(ref_pulse),
        .busy_o(ref_busy)
    );

    bpm_fifo #(.W(TS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_s(q_in),
        .out_s(q_out)
    );

    // free-running timestamp
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            now_r <= '0;
        end else begin
            now_r <= now_r + 1'b1;
        end
    end

    assign rx_blank_o = (dblank_r != 16'd0) || (txk_r != 16'd0) || (gap_r != 16'd0);
    assign vid_rise = video_i && !vid_d_r && !rx_blank_o;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vid_d_r <= 1'b0;
        end else begin
            vid_d_r <= video_i;
        end
    end

    // pair decoder: second pulse must land 12 us after first
    assign dec_hit = vid_rise && pair_arm_r && (pair_cnt_r >= 16'(PAIR_CYC - PAIR_TOL_CYC))
        && (pair_cnt_r <= 16'(PAIR_CYC + PAIR_TOL_CYC));
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pair_arm_r <= 1'b0;
            pair_cnt_r <= '0;
        end else if (dec_hit || rx_blank_o) begin
            pair_arm_r <= 1'b0;
        end else if (vid_rise) begin
            pair_arm_r <= 1'b1;
            pair_cnt_r <= 16'd1;
        end else if (pair_arm_r) begin
            if (pair_cnt_r > 16'(PAIR_CYC + PAIR_TOL_CYC)) begin
                pair_arm_r <= 1'b0;
            end else begin
                pair_cnt_r <= pair_cnt_r + 16'd1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            decode_o <= 1'b0;
        end else begin
            decode_o <= dec_hit;
        end
    end

    // post-decode blanking and minimum output spacing
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dblank_r <= '0;
        end else if (dec_hit) begin
            dblank_r <= 16'(DEC_BLANK_CYC);
        end else if (dblank_r != 16'd0) begin
            dblank_r <= dblank_r - 16'd1;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_r <= '0;
        end else if (dec_hit) begin
            gap_r <= 16'(MIN_OUT_CYC - PAIR_CYC + PAIR_TOL_CYC);
        end else if (gap_r != 16'd0) begin
            gap_r <= gap_r - 16'd1;
        end
    end

    // reply queue: timestamps of decodes
    assign q_in.valid = dec_hit;
    assign q_in.data = now_r;
    assign dist_due = q_out.valid && ((now_r - q_out.data) == TS_W'(ZERO_DIST));
    assign q_out.ready = dist_due || (q_out.valid && ((now_r - q_out.data) > TS_W'(ZERO_DIST)));

    // identification tone pulses
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            id_cnt_r <= '0;
        end else if (!id_key_i || id_cnt_r == 16'(ID_PERIOD - 1)) begin
            id_cnt_r <= '0;
        end else begin
            id_cnt_r <= id_cnt_r + 16'd1;
        end
    end
    assign id_pulse = id_key_i && (id_cnt_r == 16'd0);

    // squitter fill, rate set by the loop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sq_cnt_r <= '0;
        end else if (sq_cnt_r >= 32'(SQ_PERIOD) - 32'(gain_o)) begin
            sq_cnt_r <= '0;
        end else begin
            sq_cnt_r <= sq_cnt_r + 32'd1;
        end
    end
    assign sq_pulse = (sq_cnt_r == 32'd0) && !id_key_i && !ref_busy && !dist_due;

    // priority merge
    always_comb begin
        merge_pulse = 1'b0;
        if (ref_pulse) begin
            merge_pulse = 1'b1;
        end else if (ref_busy) begin
            merge_pulse = 1'b0;
        end else if (id_key_i) begin
            merge_pulse = id_pulse;
        end else if (dist_due) begin
            merge_pulse = 1'b1;
        end else begin
            merge_pulse = sq_pulse;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reply_drop_o <= 1'b0;
        end else begin
            reply_drop_o <= dist_due && (ref_busy || id_key_i);
        end
    end

    // pair encoder; a reference pulse restarts it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enc_r <= '0;
            enc_busy_r <= 1'b0;
            tx_pulse_o <= 1'b0;
        end else begin
            tx_pulse_o <= 1'b0;
            if (merge_pulse && (ref_pulse || !enc_busy_r)) begin
                enc_r <= '0;
                enc_busy_r <= 1'b1;
                tx_pulse_o <= 1'b1;
            end else if (enc_busy_r) begin
                enc_r <= enc_r + 16'd1;
                if (enc_r == 16'(PAIR_CYC - 1)) begin
                    tx_pulse_o <= 1'b1;
                    enc_busy_r <= 1'b0;
                end
            end
        end
    end

    // transmit keying window
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            txk_r <= '0;
        end else if (tx_pulse_o) begin
            txk_r <= 16'(TX_KEY_CYC);
        end else if (txk_r != 16'd0) begin
            txk_r <= txk_r - 16'd1;
        end
    end
    assign tx_key_o = (txk_r != 16'd0);

    // rate loop: count decodes per one-second window
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            win_r <= '0;
            dec_cnt_r <= '0;
            gain_o <= GAIN_RST;
        end else if (win_r == 32'(RATE_WIN - 1)) begin
            win_r <= '0;
            dec_cnt_r <= '0;
            if (dec_cnt_r < 16'(RATE_TARGET - RATE_TOL) && gain_o != GAIN_MAX) begin
                gain_o <= gain_o + GAIN_STEP;
            end else if (dec_cnt_r > 16'(RATE_TARGET + RATE_TOL) && gain_o != GAIN_MIN) begin
                gain_o <= gain_o - GAIN_STEP;
            end
        end else begin
            win_r <= win_r + 32'd1;
            if (dec_hit) begin
                dec_cnt_r <= dec_cnt_r + 16'd1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== pkg/bpm_pkg.sv ====
// package: timing constants and state types for the beacon pulse mux
package bpm_pkg;
    localparam int CLK_MHZ = 100;
    localparam int ZERO_DIST_US = 50;
    localparam int ZERO_DIST_CYC = ZERO_DIST_US * CLK_MHZ;
    localparam int ID_RATE_HZ = 1350;
    localparam int ID_PERIOD_CYC = (CLK_MHZ * 1000000) / ID_RATE_HZ;
    localparam int PAIR_US = 12;
    localparam int PAIR_CYC = PAIR_US * CLK_MHZ;
    localparam int PAIR_TOL_CYC = 1 * CLK_MHZ / 2;
    localparam int DEC_BLANK_US = 40;
    localparam int DEC_BLANK_CYC = DEC_BLANK_US * CLK_MHZ;
    localparam int MIN_OUT_US = 65;
    localparam int MIN_OUT_CYC = MIN_OUT_US * CLK_MHZ;
    localparam int TX_KEY_US = 10;
    localparam int TX_KEY_CYC = TX_KEY_US * CLK_MHZ;
    localparam int RATE_TARGET = 2700;
    localparam int RATE_TOL = 90;
    localparam int RATE_WIN_CYC = CLK_MHZ * 1000000;
    localparam int FINE_COUNT = 6;
    localparam int FINE_SPACE_CYC = 24 * CLK_MHZ;
    localparam int COARSE_COUNT = 12;
    localparam int COARSE_SPACE_CYC = 30 * CLK_MHZ;
    localparam int SQ_PERIOD_CYC = CLK_MHZ * 1000000 / RATE_TARGET;
    localparam int GAIN_W = 8;
    localparam logic [GAIN_W-1:0] GAIN_RST = 8'h80;
    localparam logic [GAIN_W-1:0] GAIN_STEP = 8'h01;
    localparam logic [GAIN_W-1:0] GAIN_MAX = 8'hff;
    localparam logic [GAIN_W-1:0] GAIN_MIN = 8'h00;
    localparam int TS_W = 24;
    localparam int FIFO_DEPTH = 16;
    typedef enum logic [1:0] {BPM_SRC_NONE, BPM_SRC_REF, BPM_SRC_ID, BPM_SRC_DIST} bpm_src_t;
    typedef enum logic [1:0] {BPM_BURST_IDLE, BPM_BURST_FINE, BPM_BURST_COARSE} bpm_burst_t;
endpackage

// ==== pkg/bpm_stream_if.sv ====
// interface: valid/ready timestamp stream between decoder side and reply fifo
`timescale 1ns/1ns
`default_nettype none
interface bpm_stream_if #(parameter int W = 24);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== verilog/bpm_fifo.sv ====
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module bpm_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    bpm_stream_if.snk in_s,
    bpm_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic full;
    logic empty;
    assign empty = (wp_r == rp_r);
    assign full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
    assign in_s.ready = !full;
    assign out_s.valid = !empty;
    assign out_s.data = mem[rp_r[AW-1:0]];
    always_ff @(posedge clk_i) begin
        if (in_s.valid && !full) begin
            mem[wp_r[AW-1:0]] <= in_s.data;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_r <= '0;
        end else if (in_s.valid && !full) begin
            wp_r <= wp_r + 1'b1;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rp_r <= '0;
        end else if (out_s.ready && !empty) begin
            rp_r <= rp_r + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/bpm_burst_gen.sv ====
// reference burst sequencer: coarse and fine bursts, coarse first on coincidence
`timescale 1ns/1ns
`default_nettype none
module bpm_burst_gen
    import bpm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic fine_trig_i,
    input wire logic coarse_trig_i,
    output logic pulse_o,
    output logic busy_o
);
    bpm_burst_t st_r;
    logic [15:0] cnt_r;
    logic [3:0] left_r;
    logic fine_pend_r;
    logic [15:0] space;
    assign space = (st_r == BPM_BURST_COARSE) ? 16'(COARSE_SPACE_CYC) : 16'(FINE_SPACE_CYC);
    assign busy_o = (st_r != BPM_BURST_IDLE);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fine_pend_r <= 1'b0;
        end else if (fine_trig_i && (coarse_trig_i || st_r != BPM_BURST_IDLE)) begin
            fine_pend_r <= 1'b1;
        end else if (st_r == BPM_BURST_IDLE) begin
            fine_pend_r <= 1'b0;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= BPM_BURST_IDLE;
            cnt_r <= '0;
            left_r <= '0;
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= 1'b0;
            unique case (st_r)
                BPM_BURST_IDLE: begin
                    if (coarse_trig_i) begin
                        st_r <= BPM_BURST_COARSE;
                        left_r <= 4'(COARSE_COUNT - 1);
                        cnt_r <= '0;
                        pulse_o <= 1'b1;
                    end else if (fine_trig_i || fine_pend_r) begin
                        st_r <= BPM_BURST_FINE;
                        left_r <= 4'(FINE_COUNT - 1);
                        cnt_r <= '0;
                        pulse_o <= 1'b1;
                    end
                end
                default: begin
                    if (cnt_r == space - 16'd1) begin
                        cnt_r <= '0;
                        if (left_r == 4'd0) begin
                            st_r <= BPM_BURST_IDLE;
                        end else begin
                            left_r <= left_r - 4'd1;
                            pulse_o <= 1'b1;
                        end
                    end else begin
                        cnt_r <= cnt_r + 16'd1;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== tb/bpm_top_checker.sv ====
// checker: timing relations at the beacon pulse mux ports
`timescale 1ns/1ns
`default_nettype none
module bpm_top_checker
    import bpm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic video_i,
    input wire logic fine_trig_i,
    input wire logic coarse_trig_i,
    input wire logic id_key_i,
    input wire logic tx_pulse_o,
    input wire logic tx_key_o,
    input wire logic rx_blank_o,
    input wire logic decode_o,
    input wire logic [GAIN_W-1:0] gain_o,
    input wire logic reply_drop_o
);
    logic vid_d_r;
    logic [15:0] vcnt_r, vgap_r, kcnt_r, dcnt_r;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    function automatic logic [15:0] step_sat(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction
    // cycles since last video edge, gap between last two edges, since tx pulse, since decode
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vid_d_r <= 1'b0;
            vcnt_r <= 16'hffff;
            vgap_r <= 16'h0000;
            kcnt_r <= 16'hffff;
            dcnt_r <= 16'hffff;
        end else begin
            vid_d_r <= video_i;
            vcnt_r <= (video_i && !vid_d_r) ? 16'h0001 : step_sat(vcnt_r);
            vgap_r <= (video_i && !vid_d_r) ? vcnt_r : vgap_r;
            kcnt_r <= tx_pulse_o ? 16'h0001 : step_sat(kcnt_r);
            dcnt_r <= decode_o ? 16'h0001 : step_sat(dcnt_r);
        end
    end
    property p_key_span;
        tx_key_o == (kcnt_r <= TX_KEY_CYC);
    endproperty
    a_key_span: assert property (p_key_span) else $error("key span");
    property p_key_blank;
        tx_key_o |-> rx_blank_o;
    endproperty
    a_key_blank: assert property (p_key_blank) else $error("key blank");
    property p_dec_blank;
        (decode_o || dcnt_r < DEC_BLANK_CYC - 1) |-> rx_blank_o;
    endproperty
    a_dec_blank: assert property (p_dec_blank) else $error("decode blank");
    property p_dec_gap;
        decode_o |-> dcnt_r >= MIN_OUT_CYC - 1;
    endproperty
    a_dec_gap: assert property (p_dec_gap) else $error("decode gap");
    property p_dec_pair;
        decode_o |-> (vgap_r >= PAIR_CYC - PAIR_TOL_CYC && vgap_r <= PAIR_CYC + PAIR_TOL_CYC);
    endproperty
    a_dec_pair: assert property (p_dec_pair) else $error("pair spacing");
    property p_dec_open;
        decode_o |-> !$past(rx_blank_o);
    endproperty
    a_dec_open: assert property (p_dec_open) else $error("decode while blank");
    property p_tx_single;
        tx_pulse_o |=> !tx_pulse_o;
    endproperty
    a_tx_single: assert property (p_tx_single) else $error("tx width");
    property p_gain_step;
        $changed(gain_o) |-> (gain_o == $past(gain_o) + GAIN_STEP || gain_o == $past(gain_o) - GAIN_STEP);
    endproperty
    a_gain_step: assert property (p_gain_step) else $error("gain step");
    c_decode: cover property (decode_o);
    c_drop: cover property (reply_drop_o);
    c_gain: cover property ($changed(gain_o));
endmodule
bind bpm_top bpm_top_checker bpm_top_checker_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .video_i(video_i), .fine_trig_i(fine_trig_i),
    .coarse_trig_i(coarse_trig_i), .id_key_i(id_key_i), .tx_pulse_o(tx_pulse_o), .tx_key_o(tx_key_o),
    .rx_blank_o(rx_blank_o), .decode_o(decode_o), .gain_o(gain_o), .reply_drop_o(reply_drop_o)
);
`default_nettype wire

// ==== tb/bpm_far_side.sv ====
// far-side model: receiver video source and transmit pulse monitor
`timescale 1ns/1ns
`default_nettype none
module bpm_far_side (
    input wire logic clk_i,
    input wire logic tx_pulse_i,
    output logic video_o
);
    longint tx_q[$];
    initial video_o = 1'b0;
    always @(posedge clk_i) begin
        if (tx_pulse_i === 1'b1) begin
            tx_q.push_back($time);
        end
    end
    // two video pulses whose rising edges are gap cycles apart
    task automatic send_pair(input int gap, output longint t2);
        @(posedge clk_i);
        #1 video_o = 1'b1;
        repeat (20) @(posedge clk_i);
        #1 video_o = 1'b0;
        repeat (gap - 20) @(posedge clk_i);
        #1 video_o = 1'b1;
        @(posedge clk_i);
        t2 = $time;
        repeat (19) @(posedge clk_i);
        #1 video_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_bpm_top.sv ====
// self-checking bench for the beacon pulse mux top
`timescale 1ns/1ns
`default_nettype none
module tb_bpm_top;
    import bpm_pkg::*;
    localparam int ZD = ZERO_DIST_CYC;
    localparam int IDP = 2000;
    typedef struct {int gap; logic dec;} bpm_row_t;
    logic clk_i, rst_n_i, video_i, fine_trig_i, coarse_trig_i, id_key_i;
    logic tx_pulse_o, tx_key_o, rx_blank_o, decode_o, reply_drop_o;
    logic [GAIN_W-1:0] gain_o;
    int num_errors = 0;
    int comparisons = 0;
    int dec_n = 0;
    int drop_n = 0;
    int n, d0, p0;
    longint t2, dec_t;
    bpm_row_t rows[6] = '{'{1200, 1'b1}, '{1150, 1'b1}, '{1250, 1'b1}, '{1149, 1'b0}, '{1251, 1'b0}, '{600, 1'b0}};
    bpm_top #(.ZERO_DIST(ZD), .RATE_WIN(20000), .SQ_PERIOD(1000000), .ID_PERIOD(IDP)) bpm_top_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .video_i(video_i), .fine_trig_i(fine_trig_i),
        .coarse_trig_i(coarse_trig_i), .id_key_i(id_key_i), .tx_pulse_o(tx_pulse_o), .tx_key_o(tx_key_o),
        .rx_blank_o(rx_blank_o), .decode_o(decode_o), .gain_o(gain_o), .reply_drop_o(reply_drop_o)
    );
    bpm_far_side bpm_far_side_i (.clk_i(clk_i), .tx_pulse_i(tx_pulse_o), .video_o(video_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (decode_o === 1'b1) begin
            dec_n++;
            dec_t = $time;
        end
        if (reply_drop_o === 1'b1) begin
            drop_n++;
        end
    end
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic quiet();
        for (int i = 0; i < 9000 && (rx_blank_o !== 1'b0 || tx_key_o !== 1'b0); i++) begin
            cyc(1);
        end
    endtask
    function automatic int ntx();
        return bpm_far_side_i.tx_q.size();
    endfunction
    function automatic longint txt(input int i);
        return bpm_far_side_i.tx_q[i];
    endfunction
    task automatic check_rst();
        check("reset outputs", {GAIN_RST, 5'h00}, {gain_o, tx_pulse_o, tx_key_o, rx_blank_o, decode_o, reply_drop_o});
    endtask
    initial begin
        @(posedge rst_n_i);
        repeat (30000) @(posedge clk_i);
        #1;
        check("gain after one window", GAIN_RST + GAIN_STEP, gain_o);
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        num_errors++;
        conclude();
    end
    initial begin
        rst_n_i = 1'b0;
        fine_trig_i = 1'b0;
        coarse_trig_i = 1'b0;
        id_key_i = 1'b0;
        cyc(5);
        check_rst();
        rst_n_i = 1'b1;
        // squitter fires its pair right after reset; let it and its keying clear
        cyc(2500);
        foreach (rows[k]) begin
            quiet();
            n = ntx();
            d0 = dec_n;
            bpm_far_side_i.send_pair(rows[k].gap, t2);
            cyc(3);
            check("decode count", rows[k].dec, dec_n - d0);
            if (rows[k].dec) begin
                check("decode time", t2 + 10, dec_t);
                cyc(ZD + PAIR_CYC + 100);
                check("reply time", t2 + (ZD + 1) * 10, txt(n));
                check("pair spacing", PAIR_CYC * 10, txt(n + 1) - txt(n));
            end
        end
        // reply falls due during keying and is dropped; id train at its own rate
        quiet();
        bpm_far_side_i.send_pair(PAIR_CYC, t2);
        cyc(200);
        p0 = drop_n;
        n = ntx();
        id_key_i = 1'b1;
        cyc(10 * IDP);
        id_key_i = 1'b0;
        check("reply dropped on key", 1, drop_n - p0);
        check("id pulse count", 1, (ntx() - n >= 19 && ntx() - n <= 21));
        cyc(PAIR_CYC + 100);
        n = ntx();
        cyc(4000);
        check("id gated off", n, ntx());
        // fine burst alone
        quiet();
        n = ntx();
        fine_trig_i = 1'b1;
        cyc(1);
        fine_trig_i = 1'b0;
        cyc(6 * FINE_SPACE_CYC + 2000);
        check("fine count", 2 * FINE_COUNT, ntx() - n);
        check("fine spacing", FINE_SPACE_CYC * 10, txt(n + 2) - txt(n));
        // coinciding triggers over a pending reply, then reset mid-burst
        quiet();
        bpm_far_side_i.send_pair(PAIR_CYC, t2);
        cyc(100);
        n = ntx();
        p0 = drop_n;
        fine_trig_i = 1'b1;
        coarse_trig_i = 1'b1;
        cyc(1);
        fine_trig_i = 1'b0;
        coarse_trig_i = 1'b0;
        cyc(5200);
        check("coarse first", COARSE_SPACE_CYC * 10, txt(n + 2) - txt(n));
        check("reply dropped on burst", 1, drop_n - p0);
        rst_n_i = 1'b0;
        cyc(2);
        check_rst();
        rst_n_i = 1'b1;
        n = ntx();
        cyc(4000);
        // only the squitter pair that restarts with its counter may follow reset
        check("burst cleared", n + 2, ntx());
        check("gain after reset", GAIN_RST, gain_o);
        conclude();
    end
endmodule
`default_nettype wire
